//--- core/sqe_merit.sv
`timescale 1ns/1ps
`default_nettype none
`include "sqe_params.svh"

module sqe_merit
  import sqe_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Source metrics.
  input wire logic i_present,
  input wire logic [19:0] i_merit_dm,
  input wire logic [9:0] i_dop_tenths,
  // Effective merit.
  output logic [19:0] o_merit_dm
);

  logic [19:0] derived;
  logic [19:0] merit_r;

  // With dilution in tenths and merit in decimetres the scale factors cancel.
  assign derived = 20'(i_dop_tenths) * 20'(`SQE_MERIT_FACTOR);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      merit_r <= 20'h00000;
    end else if (i_present) begin
      merit_r <= i_merit_dm; // RULE18
    end else begin
      merit_r <= derived; // RULE7
    end
  end

  assign o_merit_dm = merit_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_merit_derived: assert property (
    !i_present |=> o_merit_dm == 20'($past(i_dop_tenths)) * 20'd12) // RULE7
    else $error("Derived merit is not twelve times the dilution.");
  chk_merit_direct: assert property (
    i_present |=> o_merit_dm == $past(i_merit_dm)) // RULE18
    else $error("Supplied merit was not passed through.");

endmodule : sqe_merit
`default_nettype wire

//--- core/sqe_params.svh
`ifndef SQE_PARAMS_SVH
`define SQE_PARAMS_SVH

// Register byte offsets.
`define SQE_OFS_CTRL 8'h00
`define SQE_OFS_HMERIT 8'h04
`define SQE_OFS_HDIL 8'h08
`define SQE_OFS_VMERIT 8'h0C
`define SQE_OFS_VDIL 8'h10
`define SQE_OFS_BUILD 8'h14
`define SQE_OFS_FIELDS 8'h18
`define SQE_OFS_MSG_HI 8'h1C
`define SQE_OFS_MSG_LO 8'h20

// Writable bit masks, which are also the reset values' complement domain.
`define SQE_CTRL_MASK 32'h0007_3F1F
`define SQE_MERIT_MASK 32'h000F_FFFF
`define SQE_DOP_MASK 32'h0000_03FF
`define SQE_CTRL_RESET 32'h0000_0000
`define SQE_MERIT_RESET 32'h0000_0000
`define SQE_DOP_RESET 32'h0000_0000

// Control register field positions, and the busy bit of the fields register.
`define SQE_CTRL_VALID 0
`define SQE_CTRL_CERT 1
`define SQE_CTRL_HPRESENT 2
`define SQE_CTRL_VPRESENT 3
`define SQE_CTRL_SURF_EN 4
`define SQE_CTRL_NAVCAT_LO 8
`define SQE_CTRL_SRCLVL_LO 12
`define SQE_CTRL_VELCAT_LO 16
`define SQE_FIELDS_BUSY 31

// Fixed field values.
`define SQE_NAVCAT_LOWCOST 4'h6
`define SQE_SRCLVL_LOWCOST 2'h1
`define SQE_VELCAT_LOWCOST 3'h1
`define SQE_SDA_VALUE 2'h1
`define SQE_TYPE_CODE 5'h1F
`define SQE_SUB_AIRBORNE 3'h0
`define SQE_SUB_SURFACE 3'h1
`define SQE_CAP_EQUIPPED 2'h1
`define SQE_VERSION 3'h2

// Merit derivation: merit = 2 * dilution * range error (metres).
`define SQE_RANGE_ERROR_M 6
`define SQE_MERIT_FACTOR (2 * `SQE_RANGE_ERROR_M)

// Horizontal merit thresholds in decimetres.
`define SQE_POSCAT_T11 20'd30
`define SQE_POSCAT_T10 20'd100
`define SQE_POSCAT_T9 20'd300
`define SQE_POSCAT_T8 20'd926
`define SQE_POSCAT_T7 20'd1852
`define SQE_POSCAT_T6 20'd5556
`define SQE_POSCAT_T5 20'd9260
`define SQE_POSCAT_T4 20'd18520
`define SQE_POSCAT_T3 20'd37040
`define SQE_POSCAT_T2 20'd74080
`define SQE_POSCAT_T1 20'd185200

// Vertical merit thresholds in decimetres.
`define SQE_VERTACC_T2 20'd450
`define SQE_VERTACC_T1 20'd1500

`endif

//--- core/sqe_pkg.sv
package sqe_pkg;

  typedef struct packed {
    logic [3:0] nav_integrity_category;
    logic [1:0] source_integrity_level;
    logic [1:0] sda;
    logic [3:0] position_accuracy_category;
    logic [2:0] velocity_accuracy_category;
    logic [1:0] geometric_vertical_accuracy;
  } sqe_fields_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EVAL,
    ST_EMIT
  } sqe_build_state_t;

endpackage : sqe_pkg

//--- core/sqe_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sqe_params.svh"

// Summary of operation
// RULE1: Valid low-cost fix gives integrity category 6.
// RULE2: Valid low-cost fix gives integrity level 1.
// RULE3: Certified source uses software-supplied integrity values.
// RULE4: Invalid position zeroes integrity category and level.
// RULE5: Design assurance field always reads 1.
// RULE6: Position accuracy category mapped from horizontal merit.
// RULE7: Missing horizontal merit is twelve times dilution.
// RULE8: Valid low-cost fix gives velocity category 1.
// RULE9: Invalid position zeroes velocity accuracy category.
// RULE10: Vertical accuracy mapped from vertical merit.
// RULE11: Missing vertical merit is twelve times dilution.
// RULE12: Status message capability marks low-cost unit.
// RULE13: Payload bits 21-22 carry 01 when equipped.
// RULE14: Surface status subtype is optional, software enabled.
// RULE15: Source ignores augmentation during type 0.
// RULE16: Source drops satellites with index 15.
// RULE17: Source applies fast and long-term corrections.
// RULE18: Source supplies horizontal merit or dilution.
// RULE19: Source supplies vertical merit or dilution.
// RULE20: Source solution uses GPS constellation only.
// RULE21: Fields re-evaluated from latest inputs per message.
module sqe_top
  import sqe_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // AXI4-Lite write address.
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [7:0] i_axi_awaddr,
  // AXI4-Lite write data.
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  // AXI4-Lite write response.
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // AXI4-Lite read address.
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [7:0] i_axi_araddr,
  // AXI4-Lite read data.
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // Encoded fields and status message payload.
  output sqe_fields_t o_fields,
  output logic [55:0] o_msg,
  output logic o_msg_valid
);

  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic [31:0] ctrl_r;
  logic [31:0] hmerit_r;
  logic [31:0] hdil_r;
  logic [31:0] vmerit_r;
  logic [31:0] vdil_r;
  logic build_req;
  logic surface_req_r;
  logic [19:0] h_merit;
  logic [19:0] v_merit;
  sqe_fields_t fields_nxt;
  sqe_fields_t fields_r;
  sqe_build_state_t state_r;
  logic [55:0] msg_r;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `SQE_OFS_CTRL) || (a == `SQE_OFS_HMERIT) ||
                 (a == `SQE_OFS_HDIL) || (a == `SQE_OFS_VMERIT) ||
                 (a == `SQE_OFS_VDIL) || (a == `SQE_OFS_BUILD) ||
                 (a == `SQE_OFS_FIELDS) || (a == `SQE_OFS_MSG_HI) ||
                 (a == `SQE_OFS_MSG_LO);
  endfunction : addr_known

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  function automatic logic [3:0] pos_cat_map(input logic [19:0] m);
    if (m < `SQE_POSCAT_T11) pos_cat_map = 4'hB;
    else if (m < `SQE_POSCAT_T10) pos_cat_map = 4'hA;
    else if (m < `SQE_POSCAT_T9) pos_cat_map = 4'h9;
    else if (m < `SQE_POSCAT_T8) pos_cat_map = 4'h8;
    else if (m < `SQE_POSCAT_T7) pos_cat_map = 4'h7;
    else if (m < `SQE_POSCAT_T6) pos_cat_map = 4'h6;
    else if (m < `SQE_POSCAT_T5) pos_cat_map = 4'h5;
    else if (m < `SQE_POSCAT_T4) pos_cat_map = 4'h4;
    else if (m < `SQE_POSCAT_T3) pos_cat_map = 4'h3;
    else if (m < `SQE_POSCAT_T2) pos_cat_map = 4'h2;
    else if (m < `SQE_POSCAT_T1) pos_cat_map = 4'h1;
    else pos_cat_map = 4'h0;
  endfunction : pos_cat_map

  function automatic logic [1:0] vert_acc_map(input logic [19:0] m);
    if (m <= `SQE_VERTACC_T2) vert_acc_map = 2'h2;
    else if (m <= `SQE_VERTACC_T1) vert_acc_map = 2'h1;
    else vert_acc_map = 2'h0;
  endfunction : vert_acc_map

  // Write channel: address and data are taken in either order, one write at a time.
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign o_axi_awready = !aw_held_r && !bvalid_r;
  assign o_axi_wready = !w_held_r && !bvalid_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (i_axi_awvalid && o_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= i_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (i_axi_wvalid && o_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= i_axi_wdata;
      w_strb_r <= i_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= addr_known(aw_addr_r) ? 2'h0 : 2'h2;
    end else if (i_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign o_axi_bvalid = bvalid_r;
  assign o_axi_bresp = bresp_r;

  // Software-held source state; read-only offsets ignore writes.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= `SQE_CTRL_RESET;
      hmerit_r <= `SQE_MERIT_RESET;
      hdil_r <= `SQE_DOP_RESET;
      vmerit_r <= `SQE_MERIT_RESET;
      vdil_r <= `SQE_DOP_RESET;
    end else if (do_write) begin
      case (aw_addr_r)
        `SQE_OFS_CTRL: ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & `SQE_CTRL_MASK;
        `SQE_OFS_HMERIT: hmerit_r <= merge(hmerit_r, w_data_r, w_strb_r) & `SQE_MERIT_MASK;
        `SQE_OFS_HDIL: hdil_r <= merge(hdil_r, w_data_r, w_strb_r) & `SQE_DOP_MASK;
        `SQE_OFS_VMERIT: vmerit_r <= merge(vmerit_r, w_data_r, w_strb_r) & `SQE_MERIT_MASK;
        `SQE_OFS_VDIL: vdil_r <= merge(vdil_r, w_data_r, w_strb_r) & `SQE_DOP_MASK;
        default: ;
      endcase
    end
  end

  assign build_req = do_write && (aw_addr_r == `SQE_OFS_BUILD) && w_strb_r[0];

  // One instance per axis keeps the merit fallback identical for both.
  sqe_merit u_hmerit (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_present(ctrl_r[`SQE_CTRL_HPRESENT]),
    .i_merit_dm(hmerit_r[19:0]),
    .i_dop_tenths(hdil_r[9:0]),
    .o_merit_dm(h_merit)
  );

  sqe_merit u_vmerit (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_present(ctrl_r[`SQE_CTRL_VPRESENT]),
    .i_merit_dm(vmerit_r[19:0]),
    .i_dop_tenths(vdil_r[9:0]),
    .o_merit_dm(v_merit)
  );

  // Accuracy and integrity fields, recomputed every cycle from live inputs.
  always_comb begin
    fields_nxt = '0;
    fields_nxt.sda = `SQE_SDA_VALUE; // RULE5
    if (ctrl_r[`SQE_CTRL_VALID]) begin
      fields_nxt.position_accuracy_category = pos_cat_map(h_merit); // RULE6
      fields_nxt.geometric_vertical_accuracy = vert_acc_map(v_merit); // RULE10 RULE11
      if (ctrl_r[`SQE_CTRL_CERT]) begin
        fields_nxt.nav_integrity_category = ctrl_r[`SQE_CTRL_NAVCAT_LO +: 4]; // RULE3
        fields_nxt.source_integrity_level = ctrl_r[`SQE_CTRL_SRCLVL_LO +: 2]; // RULE3
        fields_nxt.velocity_accuracy_category = ctrl_r[`SQE_CTRL_VELCAT_LO +: 3];
      end else begin
        fields_nxt.nav_integrity_category = `SQE_NAVCAT_LOWCOST; // RULE1
        fields_nxt.source_integrity_level = `SQE_SRCLVL_LOWCOST; // RULE2
        fields_nxt.velocity_accuracy_category = `SQE_VELCAT_LOWCOST; // RULE8
      end
    end
    // An invalid fix leaves the integrity and velocity fields at zero. RULE4 RULE9
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fields_r <= '0;
    end else begin
      fields_r <= fields_nxt;
    end
  end

  assign o_fields = fields_r;

  // Build sequencer; a request that arrives while busy is dropped.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
      surface_req_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (build_req) begin
            state_r <= ST_EVAL;
            surface_req_r <= w_data_r[0] && ctrl_r[`SQE_CTRL_SURF_EN]; // RULE14
          end
        end
        ST_EVAL: state_r <= ST_EMIT;
        ST_EMIT: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Payload is latched from the live field values, never from an older copy.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      msg_r <= 56'h00_0000_0000_0000;
    end else if (state_r == ST_EVAL) begin
      msg_r <= '0;
      msg_r[55:51] <= `SQE_TYPE_CODE; // RULE12
      msg_r[50:48] <= surface_req_r ? `SQE_SUB_SURFACE : `SQE_SUB_AIRBORNE; // RULE14
      msg_r[35:34] <= `SQE_CAP_EQUIPPED; // RULE12 RULE13
      msg_r[17:16] <= fields_nxt.sda; // RULE21
      msg_r[15:13] <= `SQE_VERSION;
      msg_r[11:8] <= fields_nxt.position_accuracy_category; // RULE21
      msg_r[7:6] <= surface_req_r ? 2'h0 : fields_nxt.geometric_vertical_accuracy; // RULE21
      msg_r[5:4] <= fields_nxt.source_integrity_level; // RULE21
    end
  end

  assign o_msg = msg_r;
  assign o_msg_valid = (state_r == ST_EMIT);

  // Read channel: one read at a time, answered one cycle after it is taken.
  assign o_axi_arready = !rvalid_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else if (i_axi_arvalid && o_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= addr_known(i_axi_araddr) ? 2'h0 : 2'h2;
      case (i_axi_araddr)
        `SQE_OFS_CTRL: rdata_r <= ctrl_r;
        `SQE_OFS_HMERIT: rdata_r <= hmerit_r;
        `SQE_OFS_HDIL: rdata_r <= hdil_r;
        `SQE_OFS_VMERIT: rdata_r <= vmerit_r;
        `SQE_OFS_VDIL: rdata_r <= vdil_r;
        `SQE_OFS_FIELDS: rdata_r <= {(state_r != ST_IDLE), 14'h0000, fields_r};
        `SQE_OFS_MSG_HI: rdata_r <= {8'h00, msg_r[55:32]};
        `SQE_OFS_MSG_LO: rdata_r <= msg_r[31:0];
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else if (i_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign o_axi_rvalid = rvalid_r;
  assign o_axi_rdata = rdata_r;
  assign o_axi_rresp = rresp_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  chk_lowcost_nav: assert property ( // RULE1
    ctrl_r[0] && !ctrl_r[1] |=> o_fields.nav_integrity_category == 4'h6)
    else $error("Low-cost valid fix did not give category 6.");
  chk_lowcost_level: assert property ( // RULE2
    ctrl_r[0] && !ctrl_r[1] |=> o_fields.source_integrity_level == 2'h1)
    else $error("Low-cost valid fix did not give level 1.");
  chk_cert_integrity: assert property ( // RULE3
    ctrl_r[0] && ctrl_r[1] |=> o_fields.nav_integrity_category == $past(ctrl_r[11:8]) &&
      o_fields.source_integrity_level == $past(ctrl_r[13:12]))
    else $error("Certified source values were not used.");
  chk_invalid_zero: assert property ( // RULE4
    !ctrl_r[0] |=> o_fields.nav_integrity_category == 4'h0 &&
      o_fields.source_integrity_level == 2'h0)
    else $error("Invalid fix did not zero integrity fields.");
  // The field register is still clear on the first edge after reset, so that edge is skipped.
  chk_sda_fixed: assert property ( // RULE5
    !$past(i_sys_rst) |-> o_fields.sda == 2'h1)
    else $error("Design assurance field is not 1.");
  chk_pos_best: assert property ( // RULE6
    ctrl_r[0] && h_merit < 20'd30 |=> o_fields.position_accuracy_category == 4'hB)
    else $error("Sub three metre merit did not map to 11.");
  chk_vel_lowcost: assert property ( // RULE8
    ctrl_r[0] && !ctrl_r[1] |=> o_fields.velocity_accuracy_category == 3'h1)
    else $error("Low-cost valid fix did not give velocity category 1.");
  chk_vel_invalid: assert property ( // RULE9
    !ctrl_r[0] |=> o_fields.velocity_accuracy_category == 3'h0)
    else $error("Invalid fix did not zero velocity category.");
  chk_vert_coarse: assert property ( // RULE10
    ctrl_r[0] && v_merit > 20'd1500 |=> o_fields.geometric_vertical_accuracy == 2'h0)
    else $error("Coarse vertical merit did not map to 0.");
  chk_msg_capclass: assert property ( // RULE13
    o_msg_valid |-> o_msg[55:51] == 5'h1F && o_msg[35:34] == 2'h1)
    else $error("Status message capability bits are wrong.");
  chk_surface_gate: assert property ( // RULE14
    build_req && state_r == ST_IDLE && !ctrl_r[4] |-> ##2 o_msg_valid && o_msg[50:48] == 3'h0)
    else $error("Surface subtype sent while disabled.");
  chk_msg_fresh: assert property ( // RULE21
    state_r == ST_EVAL |=> o_msg_valid &&
      o_msg[11:8] == $past(fields_nxt.position_accuracy_category) &&
      o_msg[5:4] == $past(fields_nxt.source_integrity_level))
    else $error("Message carries stale field values.");

  cov_lowcost_msg: cover property (ctrl_r[0] && !ctrl_r[1] ##1 o_msg_valid);
  cov_cert_msg: cover property (ctrl_r[0] && ctrl_r[1] ##1 o_msg_valid);
  cov_surface_msg: cover property (o_msg_valid && o_msg[50:48] == 3'h1);
  cov_bad_read: cover property (o_axi_rvalid && o_axi_rresp == 2'h2);

endmodule : sqe_top
`default_nettype wire

//--- test/sqe_gnss_src.sv
`timescale 1ns/1ps
`default_nettype none

module sqe_gnss_src (
  // Clock and fix request.
  input wire logic i_clk,
  input wire logic i_next,
  input wire logic [31:0] i_rnd,
  // Fix and its metrics.
  output logic o_valid,
  output logic o_hp,
  output logic o_vp,
  output logic [19:0] o_hm,
  output logic [19:0] o_vm,
  output logic [9:0] o_hdil,
  output logic [9:0] o_vdil
);
  logic [3:0] idx;
  logic corr;
  // A satellite whose correction index reads 15 is dropped, which here costs the fix.
  assign idx = i_rnd[3:0];
  // Corrections are not used while the augmentation broadcast is message type 0.
  assign corr = i_rnd[6:4] != 3'h0;
  always_ff @(posedge i_clk) begin
    if (i_next) begin
      o_valid <= i_rnd[31] & (idx != 4'hF);
      o_hp <= i_rnd[7];
      o_vp <= i_rnd[8];
      // Applied corrections shrink the error, so a raw solution reports a larger merit.
      o_hm <= corr ? {4'h0, i_rnd[25:10]} : i_rnd[29:10];
      o_vm <= corr ? {4'h0, i_rnd[26:11]} : i_rnd[30:11];
      o_hdil <= i_rnd[21:12] >> i_rnd[9:8];
      o_vdil <= i_rnd[23:14] >> i_rnd[10:9];
    end
  end
endmodule : sqe_gnss_src

`default_nettype wire

//--- test/tb_surveillance_quality_field_encoder.sv
`timescale 1ns/1ps
`default_nettype none

module tb_surveillance_quality_field_encoder;
  import sqe_pkg::*;
  logic i_clk = 0;
  logic i_sys_rst = 1;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, nx = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, seed = 32'hB4571DD0, d, ctrl, cap;
  logic [3:0] ws = 4'hF;
  logic [1:0] r;
  logic awr, wr_rdy, bv, arr, rv, mv, sv, shp, svp;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [55:0] msg;
  logic [19:0] shm, svm, hm, vm;
  logic [9:0] shd, svd;
  sqe_fields_t fo, ef;
  int failures = 0, n_checks = 0, n_msg = 0, i, m0, k;
  int thr[11] = '{30, 100, 300, 926, 1852, 5556, 9260, 18520, 37040, 74080, 185200};

  always #2.5 i_clk = ~i_clk;

  sqe_top u_sqe_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_axi_awvalid(awv),
    .o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wr_rdy),
    .i_axi_wdata(wd), .i_axi_wstrb(ws), .o_axi_bvalid(bv), .i_axi_bready(bry),
    .o_axi_bresp(bresp), .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara),
    .o_axi_rvalid(rv), .i_axi_rready(rry), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
    .o_fields(fo), .o_msg(msg), .o_msg_valid(mv));

  sqe_gnss_src u_sqe_gnss_src (.i_clk(i_clk), .i_next(nx), .i_rnd(seed), .o_valid(sv),
    .o_hp(shp), .o_vp(svp), .o_hm(shm), .o_vm(svm), .o_hdil(shd), .o_vdil(svd));

  // The payload is captured where the pulse stands, so no build is missed by a bus task.
  always @(posedge i_clk) begin
    if (mv === 1'b1) begin
      n_msg++;
      cap = msg[31:0];
      cap = {msg[55:48], msg[35:34], msg[17:16], msg[11:4], 12'h0};
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function automatic sqe_fields_t model(input logic [31:0] c, input int h0, hd, v0, vd);
    sqe_fields_t f;
    int h, v, j;
    f = '0;
    f.sda = 2'h1;
    h = c[2] ? h0 : 12 * hd;
    v = c[3] ? v0 : 12 * vd;
    if (c[0]) begin
      f.nav_integrity_category = c[1] ? c[11:8] : 4'h6;
      f.source_integrity_level = c[1] ? c[13:12] : 2'h1;
      f.velocity_accuracy_category = c[1] ? c[18:16] : 3'h1;
      for (j = 10; j >= 0; j--) begin
        if (h < thr[j]) f.position_accuracy_category = 4'(11 - j);
      end
      f.geometric_vertical_accuracy = (v <= 450) ? 2'h2 : (v <= 1500) ? 2'h1 : 2'h0;
    end
    return f;
  endfunction : model

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic hang(input int n);
    if (n >= 50) begin
      failures++;
      end_of_test();
    end
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= v;
    bry <= 1;
    do begin
      @(posedge i_clk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
      n++;
    end while (bv !== 1'b1 && n < 50);
    rs = bresp;
    bry <= 0;
    hang(n);
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    arv <= 1;
    ara <= a;
    rry <= 1;
    do begin
      @(posedge i_clk);
      if (arr) arv <= 0;
      n++;
    end while (rv !== 1'b1 && n < 50);
    v = rdata;
    rs = rresp;
    rry <= 0;
    hang(n);
    @(posedge i_clk);
  endtask : rd

  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 0;
    @(posedge i_clk);
    rd(8'h00, d, r);
    chk("ctrl_reset", d, 32'h0);
    rd(8'h40, d, r);
    chk("unmapped_rresp", r, 2'h2);
    chk("unmapped_rdata", d, 32'h0);
    wr(8'h40, 32'hFFFFFFFF, r);
    chk("unmapped_bresp", r, 2'h2);
    for (i = 0; i < 40; i++) begin
      seed = xs(seed);
      nx <= 1;
      @(posedge i_clk);
      nx <= 0;
      @(posedge i_clk);
      // The first passes sit on each horizontal threshold and one below it.
      hm = (i < 22) ? 20'(thr[i / 2] - i % 2) : shm >> seed[27:24];
      vm = svm >> seed[27:24];
      ctrl = {13'h0, seed[18:16], 2'h0, seed[13:12], seed[11:8], 3'h0, seed[4],
              svp, shp | (i < 22), seed[1], sv | (i < 22)};
      ef = model(ctrl, hm, shd, vm, svd);
      wr(8'h00, ctrl, r);
      chk("ctrl_bresp", r, 2'h0);
      wr(8'h04, {12'h0, hm}, r);
      wr(8'h08, {22'h0, shd}, r);
      wr(8'h0C, {12'h0, vm}, r);
      wr(8'h10, {22'h0, svd}, r);
      repeat (3) @(posedge i_clk);
      chk("o_fields", fo, ef);
      rd(8'h18, d, r);
      chk("fields_reg", d, {15'h0, ef});
      m0 = n_msg;
      wr(8'h14, {31'h0, seed[20]}, r);
      for (k = 0; k < 50 && n_msg == m0; k++) @(posedge i_clk);
      hang(k);
      chk("msg_count", n_msg, m0 + 1);
      chk("msg_type", cap[31:27], 5'h1F);
      chk("msg_subtype", cap[26:24], {2'h0, seed[20] & ctrl[4]});
      chk("msg_capability", cap[23:22], 2'h1);
      chk("msg_sda", cap[21:20], 2'h1);
      chk("msg_pos_accuracy", cap[19:16], ef.position_accuracy_category);
      // A surface message carries no vertical accuracy.
      if (seed[20] & ctrl[4]) ef.geometric_vertical_accuracy = 2'h0;
      chk("msg_vert_accuracy", cap[15:14], ef.geometric_vertical_accuracy);
      chk("msg_src_integrity", cap[13:12], ef.source_integrity_level);
    end
    end_of_test();
  end
endmodule : tb_surveillance_quality_field_encoder

`default_nettype wire
